// [ulsi_regs.svh]
// register indices, field positions, reset values and codes of the line status block
`ifndef ULSI_REGS_SVH
`define ULSI_REGS_SVH

// register indices; byte address is four times the index
`define ULSI_IDX_RXTX      3'h0
`define ULSI_IDX_IER       3'h1
`define ULSI_IDX_IDENT     3'h2
`define ULSI_IDX_LCR       3'h3
`define ULSI_IDX_STATUS    3'h5
`define ULSI_IDX_MSR       3'h6

// interrupt enable bits
`define ULSI_IER_RDA       0
`define ULSI_IER_TXE       1
`define ULSI_IER_LS        2
`define ULSI_IER_MS        3

// fifo control bits
`define ULSI_FCR_EN        0
`define ULSI_FCR_RXRST     1
`define ULSI_FCR_TXRST     2

// interrupt identity codes, bits 3:0
`define ULSI_ID_NONE       4'h1
`define ULSI_ID_LS         4'h6
`define ULSI_ID_RDA        4'h4
`define ULSI_ID_TO         4'hC
`define ULSI_ID_TXE        4'h2
`define ULSI_ID_MS         4'h0

// reset values
`define ULSI_IDENT_RST     8'h01
`define ULSI_LCR_RST       8'h00
`define ULSI_IER_RST       4'h0

// receive trigger levels
`define ULSI_TRIG_0        5'h01
`define ULSI_TRIG_1        5'h04
`define ULSI_TRIG_2        5'h08
`define ULSI_TRIG_3        5'h0E

// timing in half bit ticks and frame arithmetic
`define ULSI_WORD_BASE     5'h05
`define ULSI_HIGH_RESUME   2'h2
`define ULSI_TO_CHARS      3
`endif

// [ulsi_pkg.sv]
// types of the line status and interrupt identity block
package ulsi_pkg;
  typedef struct packed {
    logic [2:0] unused;
    logic       even_sel;
    logic       par_en;
    logic       stop2;
    logic [1:0] word_len;
  } ulsi_lcr_t;

  typedef enum logic [2:0] {
    ULSI_TX_EMPTY = 3'b001,
    ULSI_TX_BUSY  = 3'b010,
    ULSI_TX_WAIT  = 3'b100
  } ulsi_tx_st_t;
endpackage : ulsi_pkg

// [ulsi_mem_if.sv]
// write and read port bundle between the control logic and a little memory
`timescale 1ns/100ps
interface ulsi_mem_if #(parameter int W = 8, parameter int AW = 4);
  logic          we;
  logic [AW-1:0] waddr;
  logic [W-1:0]  wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0]  rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ulsi_mem_if

// [ulsi_fifo_mem.sv]
// little memory with registered read data for the transmit and receive queues
`timescale 1ns/100ps
module ulsi_fifo_mem #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  input wire logic pclk,
  ulsi_mem_if.mem  port
);
  logic [W-1:0] store [0:(1<<AW)-1];

  // write, and read the addressed word one edge later
  always_ff @(posedge pclk)
  begin
    if (port.we)
    begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end
endmodule : ulsi_fifo_mem

// [ulsi_half_tick.sv]
// divider giving a one-cycle pulse every half bit time
`timescale 1ns/100ps
module ulsi_half_tick #(
  parameter int        DW       = 16,
  parameter bit [15:0] HALF_DIV = 16'h0100
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      half_tick
);
  logic [DW-1:0] cnt;

  // count down and pulse on wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt       <= '0;
      half_tick <= 1'b0;
    end
    else
    begin
      half_tick <= (cnt == '0);
      cnt       <= (cnt == '0) ? DW'(HALF_DIV - 16'h0001) : cnt - 1'b1;
    end
  end
endmodule : ulsi_half_tick

// [ulsi_top.sv]
// line status, interrupt identity and queue logic of the serial element
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "ulsi_regs.svh"

module ulsi_top
  import ulsi_pkg::*;
#(
  parameter int        DEPTH    = 16,
  parameter int        AW       = 4,
  parameter bit [15:0] HALF_DIV = 16'h0100
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_char_parity,
  input  wire logic        rx_char_stop,
  output logic             rx_enable,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_take,
  input  wire logic        tx_shift_idle,
  input  wire logic [3:0]  modem_lines,
  input  wire logic        modem_change
);
  localparam logic [AW:0] CAP = (AW+1)'(DEPTH);

  // frame length in bits for the current line setup
  function automatic logic [4:0] frame_bits(input ulsi_lcr_t c);
    frame_bits = 5'h01 + `ULSI_WORD_BASE + {3'h0, c.word_len}
               + {4'h0, c.par_en} + (c.stop2 ? 5'h02 : 5'h01);
  endfunction : frame_bits

  // trigger level from fifo control bits
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h0: trig_level = `ULSI_TRIG_0;
      2'h1: trig_level = `ULSI_TRIG_1;
      2'h2: trig_level = `ULSI_TRIG_2;
      2'h3: trig_level = `ULSI_TRIG_3;
    endcase
  endfunction : trig_level

  ulsi_mem_if #(.W(11), .AW(AW)) rxm ();
  ulsi_mem_if #(.W(8),  .AW(AW)) txm ();

  ulsi_fifo_mem #(.W(11), .AW(AW)) u_rx_mem (.pclk(pclk), .port(rxm.mem));
  ulsi_fifo_mem #(.W(8),  .AW(AW)) u_tx_mem (.pclk(pclk), .port(txm.mem));

  logic half_tick;
  ulsi_half_tick #(.DW(16), .HALF_DIV(HALF_DIV)) u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .half_tick (half_tick)
  );

  logic [3:0]    ier;
  ulsi_lcr_t     lcr;
  logic          fifo_en;
  logic [1:0]    trig_sel;
  logic [7:0]    interrupt_identity;
  logic [3:0]    err;
  logic          rx_ready;
  logic          tx_holding_empty;
  logic          temt;
  logic [AW:0]   rx_count;
  logic [AW-1:0] rx_wp;
  logic [AW-1:0] rx_rp;
  logic [1:0]    rx_top_new;
  logic [AW:0]   tx_count;
  logic [AW-1:0] tx_wp;
  logic [AW-1:0] tx_rp;
  logic          two_seen;
  ulsi_tx_st_t   tx_st;
  logic [7:0]    tx_wait;
  logic [7:0]    low_cnt;
  logic [1:0]    high_cnt;
  logic          brk_push;
  logic [7:0]    to_cnt;
  logic          to_flag;
  logic          txe_irq;
  logic          txe_q;
  logic          modem_flag;

  // bus decode
  logic [2:0] idx;
  logic       setup_hit;
  logic       wr_done;
  logic       rd_done;
  logic       mapped;
  assign idx       = paddr[4:2];
  assign setup_hit = psel & penable & !pready;
  assign wr_done   = psel & penable & pready & pwrite;
  assign rd_done   = psel & penable & pready & !pwrite;
  assign mapped    = (idx != 3'h4) && (idx != 3'h7);

  logic       fcr_wr;
  logic       mode_change;
  logic       rx_flush;
  logic       tx_flush;
  assign fcr_wr      = wr_done & (idx == `ULSI_IDX_IDENT);
  assign mode_change = fcr_wr & (pwdata[`ULSI_FCR_EN] != fifo_en);
  assign rx_flush    = mode_change | (fcr_wr & fifo_en & pwdata[`ULSI_FCR_RXRST]);
  assign tx_flush    = mode_change | (fcr_wr & fifo_en & pwdata[`ULSI_FCR_TXRST]);

  // receive queue control; capacity one in character mode
  logic [AW:0] rx_cap;
  logic        rx_push;
  logic        rx_pop;
  logic        rx_full;
  logic        rx_accept;
  logic        rx_over;
  logic        par_err_now;
  logic        status_rd;
  assign rx_cap    = fifo_en ? CAP : (AW+1)'(1);
  assign rx_push   = (rx_char_valid & rx_enable) | brk_push;
  assign rx_pop    = rd_done & (idx == `ULSI_IDX_RXTX) & (rx_count != '0);
  assign rx_full   = (rx_count == rx_cap);
  assign rx_accept = rx_push & (!rx_full | rx_pop);
  assign rx_over   = rx_push & rx_full & !rx_pop;
  assign status_rd = rd_done & (idx == `ULSI_IDX_STATUS);
  assign par_err_now = lcr.par_en
                   & ((^(rx_char_data & (8'hFF >> (2'h3 - lcr.word_len))))
                   ^ rx_char_parity ^ !lcr.even_sel);

  // stored word: break, framing, parity, data
  assign rxm.we    = rx_accept | (rx_over & !fifo_en);
  assign rxm.waddr = rx_accept ? rx_wp : rx_rp;
  assign rxm.wdata = brk_push ? {1'b1, 1'b1, 1'b0, 8'h00}
                              : {1'b0, !rx_char_stop, par_err_now, rx_char_data};
  assign rxm.raddr = rx_rp;

  // receive pointers and count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_count <= '0;
      rx_wp    <= '0;
      rx_rp    <= '0;
    end
    else if (rx_flush)
    begin
      rx_count <= '0;
      rx_wp    <= '0;
      rx_rp    <= '0;
    end
    else
    begin
      if (rx_accept)
      begin
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_pop)
      begin
        rx_rp <= rx_rp + 1'b1;
      end
      rx_count <= rx_count + (AW+1)'(rx_accept) - (AW+1)'(rx_pop);
    end
  end

  // new top word becomes readable two edges later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_top_new <= 2'h0;
    end
    else
    begin
      rx_top_new <= {rx_top_new[0],
                     rx_pop | (rx_accept & (rx_count == '0)) | (rx_over & !fifo_en)};
    end
  end

  // data ready follows occupancy, writable by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_ready <= 1'b0;
    end
    else if (wr_done & (idx == `ULSI_IDX_STATUS))
    begin
      rx_ready <= pwdata[0];
    end
    else if (rx_flush)
    begin
      rx_ready <= 1'b0;
    end
    else if (rx_accept | rx_pop)
    begin
      rx_ready <= (rx_count + (AW+1)'(rx_accept) - (AW+1)'(rx_pop)) != '0;
    end
  end

  // error flags {break, framing, parity, overrun}; set wins over clear
  logic [3:0] err_set;
  assign err_set = {(rx_top_new[1] & (rx_count != '0)) ? rxm.rdata[10:8] : 3'h0,
                    rx_over};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err <= 4'h0;
    end
    else if (wr_done & (idx == `ULSI_IDX_STATUS))
    begin
      err <= pwdata[4:1] | err_set;
    end
    else
    begin
      err <= (status_rd ? 4'h0 : err) | err_set;
    end
  end

  // break detector on the serial input in half bit steps
  logic [7:0] brk_limit;
  assign brk_limit = {2'h0, frame_bits(lcr), 1'b0} + 8'h01;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt   <= 8'h00;
      high_cnt  <= 2'h0;
      brk_push  <= 1'b0;
      rx_enable <= 1'b1;
    end
    else
    begin
      brk_push <= 1'b0;
      if (serial_in)
      begin
        low_cnt <= 8'h00;
        if (half_tick && high_cnt != `ULSI_HIGH_RESUME)
        begin
          high_cnt <= high_cnt + 1'b1;
        end
        if (high_cnt == `ULSI_HIGH_RESUME)
        begin
          rx_enable <= 1'b1;
        end
      end
      else
      begin
        high_cnt <= 2'h0;
        if (half_tick && rx_enable)
        begin
          low_cnt <= low_cnt + 1'b1;
          if (low_cnt + 8'h01 == brk_limit)
          begin
            brk_push  <= 1'b1;
            rx_enable <= 1'b0;
          end
        end
      end
    end
  end

  // character timeout: four idle character times with data held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      to_cnt  <= 8'h00;
      to_flag <= 1'b0;
    end
    else
    begin
      if (!fifo_en || rx_count == '0 || rx_accept || rx_pop)
      begin
        to_cnt <= 8'h00;
      end
      else if (half_tick && to_cnt != {frame_bits(lcr), `ULSI_TO_CHARS'(0)})
      begin
        to_cnt <= to_cnt + 1'b1;
      end
      if (fifo_en && rx_count != '0 && !rx_accept && !rx_pop
          && to_cnt == {frame_bits(lcr), `ULSI_TO_CHARS'(0)})
      begin
        to_flag <= 1'b1;
      end
      else if ((rd_done && idx == `ULSI_IDX_RXTX) || rx_flush)
      begin
        to_flag <= 1'b0;
      end
    end
  end

  // transmit queue; capacity one in character mode
  logic [AW:0] tx_cap;
  logic        tx_push;
  logic        tx_pop;
  assign tx_cap    = fifo_en ? CAP : (AW+1)'(1);
  assign tx_push   = wr_done & (idx == `ULSI_IDX_RXTX) & (tx_count != tx_cap);
  assign tx_pop    = tx_take & tx_valid;
  assign txm.we    = tx_push;
  assign txm.waddr = tx_wp;
  assign txm.wdata = pwdata[7:0];
  assign txm.raddr = tx_rp;
  assign tx_data   = txm.rdata;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_count <= '0;
      tx_wp    <= '0;
      tx_rp    <= '0;
      tx_valid <= 1'b0;
      two_seen <= 1'b0;
    end
    else if (tx_flush)
    begin
      tx_count <= '0;
      tx_wp    <= '0;
      tx_rp    <= '0;
      tx_valid <= 1'b0;
      two_seen <= 1'b0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_wp <= tx_wp + 1'b1;
      end
      if (tx_pop)
      begin
        tx_rp <= tx_rp + 1'b1;
      end
      tx_count <= tx_count + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      tx_valid <= (tx_count != '0) && !tx_pop;
      if (tx_count >= (AW+1)'(2))
      begin
        two_seen <= 1'b1;
      end
      else if (tx_count == '0 && tx_st == ULSI_TX_EMPTY)
      begin
        two_seen <= 1'b0;
      end
    end
  end

  // holding-empty flag with lone-character delay in fifo mode
  logic tx_gone;
  assign tx_gone = tx_pop & (tx_count == (AW+1)'(1)) & !tx_push;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_holding_empty <= 1'b1;
      tx_st            <= ULSI_TX_EMPTY;
      tx_wait          <= 8'h00;
    end
    else if (wr_done & (idx == `ULSI_IDX_STATUS))
    begin
      tx_holding_empty <= pwdata[5];
    end
    else if (tx_flush)
    begin
      tx_holding_empty <= 1'b1;
      tx_st            <= ULSI_TX_EMPTY;
    end
    else if (tx_push)
    begin
      tx_holding_empty <= 1'b0;
      tx_st            <= ULSI_TX_BUSY;
    end
    else
    begin
      unique case (tx_st)
        ULSI_TX_EMPTY: tx_holding_empty <= 1'b1;
        ULSI_TX_BUSY:
        begin
          if (tx_gone && fifo_en && !two_seen)
          begin
            tx_st   <= ULSI_TX_WAIT;
            tx_wait <= {2'h0, frame_bits(lcr) - 5'h01, 1'b0};
          end
          else if (tx_gone)
          begin
            tx_holding_empty <= 1'b1;
            tx_st            <= ULSI_TX_EMPTY;
          end
        end
        ULSI_TX_WAIT:
        begin
          if (tx_wait == 8'h00)
          begin
            tx_holding_empty <= 1'b1;
            tx_st            <= ULSI_TX_EMPTY;
          end
          else if (half_tick)
          begin
            tx_wait <= tx_wait - 8'h01;
          end
        end
      endcase
    end
  end

  // transmitter empty and holding-empty edge memory
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temt  <= 1'b1;
      txe_q <= 1'b1;
    end
    else
    begin
      temt  <= tx_holding_empty & tx_shift_idle;
      txe_q <= tx_holding_empty;
    end
  end

  // transmit and modem interrupt flags; set wins over clear
  logic txe_clr;
  assign txe_clr = tx_push
                 | (rd_done & (idx == `ULSI_IDX_IDENT)
                    & (interrupt_identity[3:0] == `ULSI_ID_TXE));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txe_irq    <= 1'b1;
      modem_flag <= 1'b0;
    end
    else
    begin
      if ((tx_holding_empty & !txe_q) | mode_change)
      begin
        txe_irq <= 1'b1;
      end
      else if (txe_clr)
      begin
        txe_irq <= 1'b0;
      end
      if (modem_change)
      begin
        modem_flag <= 1'b1;
      end
      else if (rd_done & (idx == `ULSI_IDX_MSR))
      begin
        modem_flag <= 1'b0;
      end
    end
  end

  // ranked identity code
  logic [3:0] next_code;
  logic       rda;
  assign rda = fifo_en ? (rx_count >= trig_level(trig_sel)) : rx_ready;
  always_comb
  begin
    if (ier[`ULSI_IER_LS] && err != 4'h0)
      next_code = `ULSI_ID_LS;
    else if (ier[`ULSI_IER_RDA] && rda)
      next_code = `ULSI_ID_RDA;
    else if (ier[`ULSI_IER_RDA] && to_flag)
      next_code = `ULSI_ID_TO;
    else if (ier[`ULSI_IER_TXE] && txe_irq)
      next_code = `ULSI_ID_TXE;
    else if (ier[`ULSI_IER_MS] && modem_flag)
      next_code = `ULSI_ID_MS;
    else
      next_code = `ULSI_ID_NONE;
  end

  // identity register, held while addressed by a read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      interrupt_identity <= `ULSI_IDENT_RST;
    end
    else if (!(psel && idx == `ULSI_IDX_IDENT && !pwrite))
    begin
      interrupt_identity <= {fifo_en, fifo_en, 2'h0, next_code};
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ier      <= `ULSI_IER_RST;
      lcr      <= `ULSI_LCR_RST;
      fifo_en  <= 1'b0;
      trig_sel <= 2'h0;
    end
    else if (wr_done)
    begin
      if (idx == `ULSI_IDX_IER)
        ier <= pwdata[3:0];
      if (idx == `ULSI_IDX_LCR)
        lcr <= pwdata[7:0];
      if (idx == `ULSI_IDX_IDENT)
      begin
        fifo_en  <= pwdata[`ULSI_FCR_EN];
        trig_sel <= pwdata[7:6];
      end
    end
  end

  // one wait state; read data captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_hit;
      pslverr <= setup_hit & !mapped;
      if (setup_hit && !pwrite)
      begin
        unique case (idx)
          `ULSI_IDX_RXTX: prdata <= {24'h0, rxm.rdata[7:0]};
          `ULSI_IDX_IER:  prdata <= {28'h0, ier};
          `ULSI_IDX_IDENT:  prdata <= {24'h0, interrupt_identity};
          `ULSI_IDX_LCR:  prdata <= {24'h0, lcr};
          `ULSI_IDX_STATUS: prdata <= {24'h0, 1'b0, temt, tx_holding_empty, err, rx_ready};
          `ULSI_IDX_MSR:  prdata <= {28'h0, modem_lines};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : ulsi_top

// [ulsi_top_checker.sv]
// port assertions of the line status block
`timescale 1ns/100ps
module ulsi_top_checker #(parameter bit [15:0] HALF_DIV = 16'h0100) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [4:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        serial_in,
  input wire logic        rx_enable,
  input wire logic        tx_valid,
  input wire logic        tx_take
);
  logic [15:0] hi_cnt;
  wire         rd_id = pready && !pwrite && paddr[4:2] == 3'h2;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles of high serial input
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) hi_cnt <= 16'h0;
    else if (!serial_in) hi_cnt <= 16'h0;
    else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h1;
  // bus answer one cycle into access
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late answer");
  // identity and status read values
  property p_id_top; rd_id |-> prdata[5:4] == 2'b00 && prdata[7] == prdata[6]; endproperty
  a_id_top: assert property (p_id_top) else $error("identity top bits");
  property p_id_pend; rd_id |-> prdata[0] == (prdata[3:0] == 4'h1); endproperty
  a_id_pend: assert property (p_id_pend) else $error("pending bit");
  property p_id_code; rd_id |-> prdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hC};
  endproperty
  a_id_code: assert property (p_id_code) else $error("identity code");
  property p_lsr7; pready && !pwrite && paddr[4:2] == 3'h5 |-> !prdata[7]; endproperty
  a_lsr7: assert property (p_lsr7) else $error("status bit 7");
  // receiver hold-off around a break
  property p_brk_on; $fell(rx_enable) |-> !$past(serial_in); endproperty
  a_brk_on: assert property (p_brk_on) else $error("hold-off while high");
  property p_brk_off; $rose(rx_enable) |-> hi_cnt >= HALF_DIV - 16'h1; endproperty
  a_brk_off: assert property (p_brk_off) else $error("early resume");
  // transmit hand-over
  property p_take; tx_take && tx_valid |=> !tx_valid; endproperty
  a_take: assert property (p_take) else $error("offer not withdrawn");
  c_brk: cover property ($fell(rx_enable));
  c_pend: cover property (rd_id && !prdata[0]);
  c_take: cover property (tx_take && tx_valid);
endmodule : ulsi_top_checker

bind ulsi_top ulsi_top_checker #(.HALF_DIV(HALF_DIV)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .serial_in, .rx_enable, .tx_valid, .tx_take);

// [ulsi_far_end.sv]
// serial side stand-in: slow shift register and character receiver
`timescale 1ns/100ps
module ulsi_far_end (
  input  wire logic       pclk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_take,
  output logic            tx_shift_idle,
  output logic            rx_char_valid,
  output logic      [7:0] rx_char_data,
  output logic            rx_char_parity,
  output logic            rx_char_stop
);
  logic [7:0] sent [$];
  int         busy = 0;
  initial {tx_take, rx_char_valid, rx_char_data, rx_char_parity, rx_char_stop} = '0;
  assign tx_shift_idle = busy == 0;
  // takes an offered character after a pause, then shifts it out
  always @(posedge pclk)
  begin
    tx_take <= 1'b0;
    busy <= busy > 0 ? busy - 1 : 0;
    if (tx_valid && busy == 0)
      busy <= 30;
    if (tx_valid && busy == 26)
    begin
      tx_take <= 1'b1;
      sent.push_back(tx_data);
    end
  end
  // one received character, then the data lines go stale
  task automatic push(input logic [7:0] v, input logic p, input logic s);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= v;
    rx_char_parity <= p;
    rx_char_stop <= s;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~v;
  endtask : push
endmodule : ulsi_far_end

// [ulsi_top_tb.sv]
// self-checking bench of the line status and interrupt identity block
`timescale 1ns/100ps
module ulsi_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        serial_in = 1'b1, fm = 1'b0, pready, pslverr, rx_enable, tx_valid, tx_take;
  logic        tx_shift_idle, rx_char_valid, rx_char_parity, rx_char_stop;
  logic [4:0]  paddr = 5'h00;
  logic [3:0]  ml = 4'h0;
  logic        mc = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  tx_data, rx_char_data, d, q [$];
  int          miscompares = 0, cmp_count = 0;
  // clock, design and serial side
  always #12.5 pclk = ~pclk;
  ulsi_top #(.HALF_DIV(16'h0004)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_in, .rx_char_valid, .rx_char_data,
    .rx_char_parity, .rx_char_stop, .rx_enable, .tx_data, .tx_valid, .tx_take, .tx_shift_idle,
    .modem_lines(ml), .modem_change(mc));
  ulsi_far_end far (.pclk, .tx_data, .tx_valid, .tx_take, .tx_shift_idle, .rx_char_valid,
    .rx_char_data, .rx_char_parity, .rx_char_stop);
  // verdict and end of run
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one bus transfer, held until the answer
  task automatic bus(input logic w, input logic [2:0] i, input logic [31:0] v);
    int n;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, v};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      miscompares++;
      stop_test;
    end
  endtask : bus
  task automatic rdchk(input logic [2:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(rd, e);
  endtask : rdchk
  // received character and the expected receive store
  task automatic rx(input logic [7:0] v, input logic p, input logic s);
    far.push(v, p, s);
    if (!fm) q = {v};
    else if (q.size() < 16) q.push_back(v);
  endtask : rx
  // main sequence
  initial
  begin
    void'($urandom(32'h52CE3702));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(3'h2, 32'h01);
    rdchk(3'h5, 32'h60);
    bus(1'b1, 3'h3, 32'h03);
    bus(1'b1, 3'h1, 32'h0F);
    rdchk(3'h2, 32'h02);
    rdchk(3'h2, 32'h01);
    d = $urandom;
    bus(1'b1, 3'h0, {24'h0, d});
    rdchk(3'h5, 32'h00);
    repeat (50) @(posedge pclk);
    chk(far.sent.pop_front(), d);
    rdchk(3'h5, 32'h60);
    rdchk(3'h2, 32'h02);
    rx(d, 1'b0, 1'b1);
    rx(~d, 1'b0, 1'b1);
    repeat (4) @(posedge pclk);
    rdchk(3'h2, 32'h06);
    rdchk(3'h5, 32'h63);
    rdchk(3'h2, 32'h04);
    rdchk(3'h0, q.pop_front());
    rdchk(3'h5, 32'h60);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 3'h3, {27'h0, i[0], 4'hB});
      d = $urandom;
      rx(d, ^d ^ !i[0] ^ i[1], !i[1]);
      repeat (4) @(posedge pclk);
      rdchk(3'h5, {28'h6, i[1], i[1], 2'b01});
      rdchk(3'h0, q.pop_front());
    end
    bus(1'b1, 3'h5, 32'hBE);
    rdchk(3'h2, 32'h06);
    rdchk(3'h5, 32'h7E);
    rdchk(3'h5, 32'h60);
    bus(1'b1, 3'h3, 32'h03);
    bus(1'b1, 3'h2, 32'h41);
    fm = 1'b1;
    rdchk(3'h2, 32'hC2);
    rx(d, 1'b0, 1'b1);
    rx(~d, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    rdchk(3'h5, 32'h61);
    rdchk(3'h0, q.pop_front());
    repeat (4) @(posedge pclk);
    rdchk(3'h5, 32'h69);
    repeat (400) @(posedge pclk);
    rdchk(3'h2, 32'hCC);
    rdchk(3'h0, q.pop_front());
    rdchk(3'h2, 32'hC1);
    repeat (17) rx(8'($urandom), 1'b0, 1'b1);
    repeat (4) @(posedge pclk);
    rdchk(3'h2, 32'hC6);
    rdchk(3'h5, 32'h63);
    rdchk(3'h2, 32'hC4);
    repeat (16) rdchk(3'h0, q.pop_front());
    rdchk(3'h5, 32'h60);
    ml <= 4'($urandom);
    mc <= 1'b1;
    @(posedge pclk);
    mc <= 1'b0;
    rdchk(3'h2, 32'hC0);
    rdchk(3'h6, {28'h0, ml});
    rdchk(3'h2, 32'hC1);
    d = $urandom;
    bus(1'b1, 3'h0, {24'h0, d});
    rdchk(3'h5, 32'h00);
    repeat (20) @(posedge pclk);
    rdchk(3'h5, 32'h00);
    repeat (100) @(posedge pclk);
    rdchk(3'h5, 32'h60);
    chk(far.sent.pop_front(), d);
    rdchk(3'h2, 32'hC2);
    serial_in <= 1'b0;
    repeat (150) @(posedge pclk);
    chk({31'h0, rx_enable}, 32'h0);
    serial_in <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({31'h0, rx_enable}, 32'h1);
    bus(1'b0, 3'h5, 32'h0);
    chk(rd & 32'h10, 32'h10);
    stop_test;
  end
endmodule : ulsi_top_tb
